/* rtl/sleep_pkg.sv */
// constants and types shared by the cyclic sleep controller
package sleep_pkg;
    localparam int unsigned CLK_HZ             = 50000000;
    localparam int unsigned TICK_MS            = 10;
    localparam int unsigned TICK_CYCLES        = CLK_HZ / 1000 * TICK_MS;
    localparam int unsigned POLL_MS            = 100;
    localparam int unsigned POLL_TICKS         = POLL_MS / TICK_MS;
    localparam logic [2:0]  MODE_CYCLIC        = 3'h4;
    localparam logic [2:0]  MODE_CYCLIC_PIN    = 3'h5;
    localparam logic [11:0] PERIOD_MIN         = 12'h020;
    localparam logic [11:0] PERIOD_MAX         = 12'hAF0;
    localparam logic [11:0] PERIOD_RST         = 12'h020;
    localparam logic [15:0] MULT_MIN           = 16'h0001;
    localparam logic [15:0] MULT_RST           = 16'h0001;
    localparam logic [15:0] HOLD_RST           = 16'h01F4;
    localparam logic [7:0]  OPT_RST            = 8'h00;
    localparam logic [2:0]  MODE_RST           = 3'h0;
    localparam int unsigned OPT_FULL_HOLD_BIT  = 1;
    localparam int unsigned OPT_EXTENDED_BIT   = 2;
    localparam logic [2:0]  ADDR_MODE          = 3'h0;
    localparam logic [2:0]  ADDR_PERIOD        = 3'h1;
    localparam logic [2:0]  ADDR_MULT          = 3'h2;
    localparam logic [2:0]  ADDR_HOLD          = 3'h3;
    localparam logic [2:0]  ADDR_OPTIONS       = 3'h4;
    localparam logic [2:0]  ADDR_FLOW          = 3'h5;
    localparam logic [2:0]  ADDR_STATUS        = 3'h6;
    localparam logic [2:0]  ADDR_COMMAND       = 3'h7;
    localparam int unsigned CMD_SLEEP_NOW_BIT  = 0;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ASLEEP,
        ST_POLL,
        ST_AWAKE
    } state_type;
endpackage : sleep_pkg

/* rtl/tick_gen.sv */
// free-running 10 ms tick from the system clock
`timescale 1ns/1ps
module tick_gen #(
    parameter int unsigned CYCLES = sleep_pkg::TICK_CYCLES
) (
    input  wire logic CLK,
    input  wire logic RST,
    output logic      tick
);
    if (CYCLES < 2) begin : g_bad_cycles
        $error("tick_gen: CYCLES must be at least 2");
    end
    logic [$clog2(CYCLES)-1:0] cnt_q;
    logic                      wrap;
    assign wrap = (cnt_q == ($clog2(CYCLES))'(CYCLES - 1));
    always_ff @(posedge CLK) begin
        if (RST) begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end else begin
            cnt_q <= wrap ? '0 : cnt_q + 1'b1;
            tick  <= wrap;
        end
    end
endmodule : tick_gen

/* rtl/down_timer.sv */
// loadable down counter in tick units, flags expiry for one cycle
`timescale 1ns/1ps
module down_timer #(
    parameter int unsigned WIDTH = 28
) (
    input  wire logic             CLK,
    input  wire logic             RST,
    input  wire logic             load,
    input  wire logic [WIDTH-1:0] value,
    input  wire logic             stop,
    input  wire logic             tick,
    output logic                  running,
    output logic                  expired
);
    logic [WIDTH-1:0] cnt_q;
    always_ff @(posedge CLK) begin
        if (RST || stop) begin
            cnt_q   <= '0;
            running <= 1'b0;
            expired <= 1'b0;
        end else if (load) begin
            cnt_q   <= value;
            running <= (value != '0);
            expired <= (value == '0);
        end else if (running && tick) begin
            cnt_q   <= cnt_q - 1'b1;
            running <= (cnt_q != {{(WIDTH-1){1'b0}}, 1'b1});
            expired <= (cnt_q == {{(WIDTH-1){1'b0}}, 1'b1});
        end else begin
            expired <= 1'b0;
        end
    end
endmodule : down_timer

/* rtl/cyclic_sleep_controller.sv */
// cyclic sleep / wake sequencer for a battery end node
//
// The address map and strobed register access were left to the implementer.
`timescale 1ns/1ps
module cyclic_sleep_controller
    import sleep_pkg::*;
#(
    parameter int unsigned TICK_CYCLES_P = sleep_pkg::TICK_CYCLES
) (
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic [2:0]  ADDR,
    input  wire logic [15:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [15:0] RDATA,
    input  wire logic        SLEEP_REQUEST_PIN,
    input  wire logic        SERIAL_DATA,
    input  wire logic        RADIO_DATA,
    input  wire logic        POLL_ACK,
    input  wire logic        POLL_PENDING,
    output logic             POLL_REQ,
    output logic             AWAKE,
    output logic             CTS_N,
    output logic             ASLEEP
);
    import sleep_pkg::*;

    if (TICK_CYCLES_P < 2) begin : g_bad_tick
        $error("TICK_CYCLES_P must be at least 2");
    end

    // configuration registers
    logic [2:0]  sleep_mode_select_q;
    logic [11:0] sleep_period_q;
    logic [15:0] sleep_period_multiplier_q;
    logic [15:0] wake_hold_time_q;
    logic [7:0]  options_q;
    logic        flow_control_config_q;

    state_type   state_q;
    state_type   state_d;
    logic        pin_q;
    logic [15:0] cycle_cnt_q;
    logic [3:0]  poll_cnt_q;
    logic        ind_q;
    logic        poll_q;

    // decode
    logic wr_mode;
    logic wr_period;
    logic wr_mult;
    logic wr_hold;
    logic wr_opt;
    logic wr_flow;
    logic wr_cmd;
    logic sleep_now;
    logic cyclic;
    logic pin_wake;
    logic extended;
    logic full_hold;
    logic awake;
    logic data_in;
    logic tick;
    logic sleep_exp;
    logic hold_exp;
    logic hold_run;
    logic enter_sleep;
    logic go_wake;
    logic count_done;
    logic raise_ind;
    logic poll_due;
    logic [27:0] sleep_len;
    logic [27:0] hold_len;

    assign wr_mode   = WR && (ADDR == ADDR_MODE);
    assign wr_period = WR && (ADDR == ADDR_PERIOD);
    assign wr_mult   = WR && (ADDR == ADDR_MULT);
    assign wr_hold   = WR && (ADDR == ADDR_HOLD);
    assign wr_opt    = WR && (ADDR == ADDR_OPTIONS);
    assign wr_flow   = WR && (ADDR == ADDR_FLOW);
    assign wr_cmd    = WR && (ADDR == ADDR_COMMAND);
    assign sleep_now = wr_cmd && WDATA[CMD_SLEEP_NOW_BIT];

    assign cyclic    = (sleep_mode_select_q == MODE_CYCLIC)
                    || (sleep_mode_select_q == MODE_CYCLIC_PIN);
    // pin only counts as a wake source in mode 5
    assign pin_wake  = (sleep_mode_select_q == MODE_CYCLIC_PIN)
                    && pin_q && !SLEEP_REQUEST_PIN;
    assign extended  = options_q[OPT_EXTENDED_BIT];
    assign full_hold = options_q[OPT_FULL_HOLD_BIT];
    assign awake     = (state_q == ST_POLL) || (state_q == ST_AWAKE);
    // data while asleep never reaches the timers
    assign data_in   = awake && (SERIAL_DATA || RADIO_DATA);

    // extended: period times multiplier; both widened first so the product keeps its top bits
    assign sleep_len = extended
                     ? 28'(sleep_period_q) * 28'(sleep_period_multiplier_q)
                     : {16'h0000, sleep_period_q};
    assign hold_len  = {12'h000, wake_hold_time_q};

    assign go_wake     = (state_q == ST_ASLEEP) && (sleep_exp || pin_wake);
    assign count_done  = (cycle_cnt_q + 16'h0001) >= sleep_period_multiplier_q;
    // indicator on each wake at multiplier 1 or when extended, else on radio data or after N cycles
    assign raise_ind   = (go_wake && (sleep_period_multiplier_q == MULT_MIN
                                      || count_done || extended))
                      || (awake && RADIO_DATA);
    assign poll_due    = (state_q == ST_AWAKE) && tick
                      && (poll_cnt_q == 4'(POLL_TICKS - 1));

    always_comb begin
        state_d     = state_q;
        enter_sleep = 1'b0;
        case (state_q)
            ST_IDLE: begin
                if (cyclic) begin
                    state_d     = ST_ASLEEP;
                    enter_sleep = 1'b1;
                end
            end
            ST_ASLEEP: begin
                if (!cyclic) state_d = ST_IDLE;
                else if (go_wake) state_d = ST_POLL;
            end
            ST_POLL: begin
                // full-hold option keeps the node up even without data
                if (POLL_ACK && (POLL_PENDING || data_in || hold_run || full_hold)) begin
                    state_d = ST_AWAKE;
                end else if (POLL_ACK) begin
                    state_d     = ST_ASLEEP;
                    enter_sleep = 1'b1;
                end
            end
            ST_AWAKE: begin
                if (hold_exp) begin
                    state_d     = ST_ASLEEP;
                    enter_sleep = 1'b1;
                end
            end
            default: state_d = ST_IDLE;
        endcase
        if (sleep_now && awake) begin
            state_d     = ST_ASLEEP;
            enter_sleep = 1'b1;
        end
        if (!cyclic && state_q != ST_IDLE) begin
            state_d     = ST_IDLE;
            enter_sleep = 1'b0;
        end
    end

    tick_gen #(
        .CYCLES (TICK_CYCLES_P)
    ) u_tick (
        .CLK  (CLK),
        .RST  (RST),
        .tick (tick)
    );

    down_timer #(
        .WIDTH (28)
    ) u_sleep_timer (
        .CLK     (CLK),
        .RST     (RST),
        .load    (enter_sleep),
        .value   (sleep_len),
        .stop    (!cyclic),
        .tick    (tick),
        .running (),
        .expired (sleep_exp)
    );

    // restarted by every data arrival; pending data or full-hold also starts it
    down_timer #(
        .WIDTH (28)
    ) u_hold_timer (
        .CLK     (CLK),
        .RST     (RST),
        .load    (data_in || (state_q == ST_POLL && POLL_ACK
                              && (POLL_PENDING || full_hold))),
        .value   (hold_len),
        .stop    (enter_sleep || !cyclic),
        .tick    (tick),
        .running (hold_run),
        .expired (hold_exp)
    );

    // config writes: out-of-range period and multiplier values are refused and the old value kept
    always_ff @(posedge CLK) begin
        if (RST) begin
            sleep_mode_select_q       <= MODE_RST;
            sleep_period_q            <= PERIOD_RST;
            sleep_period_multiplier_q <= MULT_RST;
            wake_hold_time_q          <= HOLD_RST;
            options_q                 <= OPT_RST;
            flow_control_config_q     <= 1'b0;
        end else begin
            if (wr_mode) sleep_mode_select_q <= WDATA[2:0];
            if (wr_period && WDATA[11:0] >= PERIOD_MIN && WDATA[11:0] <= PERIOD_MAX
                && WDATA[15:12] == 4'h0) begin
                sleep_period_q <= WDATA[11:0];
            end
            if (wr_mult && WDATA >= MULT_MIN) sleep_period_multiplier_q <= WDATA;
            if (wr_hold) wake_hold_time_q <= WDATA;
            if (wr_opt) options_q <= WDATA[7:0];
            if (wr_flow) flow_control_config_q <= WDATA[0];
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            state_q <= ST_IDLE;
            pin_q   <= 1'b0;
        end else begin
            state_q <= state_d;
            pin_q   <= SLEEP_REQUEST_PIN;
        end
    end

    // wake-cycle counter for silent polls
    always_ff @(posedge CLK) begin
        if (RST || !cyclic) begin
            cycle_cnt_q <= 16'h0000;
        end else if (raise_ind) begin
            cycle_cnt_q <= 16'h0000;
        end else if (go_wake) begin
            cycle_cnt_q <= cycle_cnt_q + 16'h0001;
        end
    end

    // indicator drops with every return to sleep
    always_ff @(posedge CLK) begin
        if (RST || !cyclic || enter_sleep || state_d == ST_ASLEEP) begin
            ind_q <= 1'b0;
        end else if (raise_ind) begin
            ind_q <= 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST || state_q != ST_AWAKE) begin
            poll_cnt_q <= 4'h0;
        end else if (tick) begin
            poll_cnt_q <= poll_due ? 4'h0 : poll_cnt_q + 4'h1;
        end
    end

    // one poll pulse on entry to wake and every 100 ms after
    always_ff @(posedge CLK) begin
        if (RST) begin
            poll_q <= 1'b0;
        end else begin
            poll_q <= go_wake || poll_due;
        end
    end

    logic [15:0] rd_mux;
    assign rd_mux = (ADDR == ADDR_MODE)    ? {13'h0000, sleep_mode_select_q}
                  : (ADDR == ADDR_PERIOD)  ? {4'h0, sleep_period_q}
                  : (ADDR == ADDR_MULT)    ? sleep_period_multiplier_q
                  : (ADDR == ADDR_HOLD)    ? wake_hold_time_q
                  : (ADDR == ADDR_OPTIONS) ? {8'h00, options_q}
                  : (ADDR == ADDR_FLOW)    ? {15'h0000, flow_control_config_q}
                  : (ADDR == ADDR_STATUS)  ? {12'h000, ind_q, hold_run, 
                                             2'(state_q)}
                  : 16'h0000;

    always_ff @(posedge CLK) begin
        if (RST) begin
            RDATA    <= 16'h0000;
            POLL_REQ <= 1'b0;
            AWAKE    <= 1'b0;
            CTS_N    <= 1'b1;
            ASLEEP   <= 1'b0;
        end else begin
            RDATA    <= RD ? rd_mux : 16'h0000;
            POLL_REQ <= poll_q;
            AWAKE    <= ind_q;
            CTS_N    <= !(flow_control_config_q && awake);
            ASLEEP   <= (state_q == ST_ASLEEP);
        end
    end
endmodule : cyclic_sleep_controller

/* verification/cyclic_sleep_controller_monitor.sv */
// port-level assertions for the cyclic sleep controller
`timescale 1ns/1ps
module sleep_monitor (
    input wire logic        CLK,
    input wire logic        RST,
    input wire logic [2:0]  ADDR,
    input wire logic [15:0] WDATA,
    input wire logic        WR,
    input wire logic        RD,
    input wire logic [15:0] RDATA,
    input wire logic        SLEEP_REQUEST_PIN,
    input wire logic        SERIAL_DATA,
    input wire logic        RADIO_DATA,
    input wire logic        POLL_ACK,
    input wire logic        POLL_PENDING,
    input wire logic        POLL_REQ,
    input wire logic        AWAKE,
    input wire logic        CTS_N,
    input wire logic        ASLEEP
);
    import sleep_pkg::*;
    logic [2:0] mode_q;
    logic       flow_q;
    wire        cyc = (mode_q == MODE_CYCLIC) || (mode_q == MODE_CYCLIC_PIN);
    // shadow copies, since registers are not visible at the ports
    always_ff @(posedge CLK) begin
        if (RST) begin
            mode_q <= MODE_RST;
            flow_q <= 1'b0;
        end else if (WR && ADDR == ADDR_MODE) begin
            mode_q <= WDATA[2:0];
        end else if (WR && ADDR == ADDR_FLOW) begin
            flow_q <= WDATA[0];
        end
    end
    default clocking @(posedge CLK); endclocking
    default disable iff (RST);
    property p_enter_cyclic; $rose(ASLEEP) |-> cyc; endproperty
    a_enter_cyclic: assert property (p_enter_cyclic)
        else $error("sleep entered outside cyclic mode");
    property p_pin_wake;
        mode_q == MODE_CYCLIC_PIN && ASLEEP && $fell(SLEEP_REQUEST_PIN) |-> ##[1:8] !ASLEEP;
    endproperty
    a_pin_wake: assert property (p_pin_wake)
        else $error("pin edge did not wake");
    property p_asleep_dark; ASLEEP && $past(ASLEEP) |-> !AWAKE; endproperty
    a_asleep_dark: assert property (p_asleep_dark)
        else $error("indicator high while asleep");
    property p_wake_lit; $rose(AWAKE) |-> ##[0:2] !ASLEEP; endproperty
    a_wake_lit: assert property (p_wake_lit)
        else $error("indicator rose without waking");
    property p_cts_off; !flow_q && !$past(flow_q) |-> CTS_N; endproperty
    a_cts_off: assert property (p_cts_off)
        else $error("cts low with flow control off");
    property p_cts_asleep; ASLEEP && $past(ASLEEP) |-> CTS_N; endproperty
    a_cts_asleep: assert property (p_cts_asleep)
        else $error("cts low while asleep");
    property p_poll_gap; POLL_REQ |=> !POLL_REQ [*8]; endproperty
    a_poll_gap: assert property (p_poll_gap)
        else $error("polls too close together");
    property p_sleep_now;
        WR && ADDR == ADDR_COMMAND && WDATA[0] && AWAKE && cyc |-> ##[1:6] ASLEEP;
    endproperty
    a_sleep_now: assert property (p_sleep_now)
        else $error("sleep-now command not obeyed");
endmodule : sleep_monitor

bind cyclic_sleep_controller sleep_monitor sleep_monitor_i (
    .CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD), .RDATA(RDATA),
    .SLEEP_REQUEST_PIN(SLEEP_REQUEST_PIN), .SERIAL_DATA(SERIAL_DATA),
    .RADIO_DATA(RADIO_DATA), .POLL_ACK(POLL_ACK), .POLL_PENDING(POLL_PENDING),
    .POLL_REQ(POLL_REQ), .AWAKE(AWAKE), .CTS_N(CTS_N), .ASLEEP(ASLEEP)
);

/* verification/parent_model.sv */
// behavioural parent node answering poll requests
`timescale 1ns/1ps
module parent_model (
    input wire logic       CLK,
    input wire logic       POLL_REQ,
    input wire logic       pend,
    input wire logic [3:0] dly,
    output logic           POLL_ACK,
    output logic           POLL_PENDING
);
    initial begin
        POLL_ACK = 1'b0;
        POLL_PENDING = 1'b0;
    end
    // pending means nothing outside the ack, so it is inverted there
    always @(posedge CLK) begin
        if (POLL_REQ) begin
            repeat (dly) @(posedge CLK);
            POLL_ACK <= 1'b1;
            POLL_PENDING <= pend;
            @(posedge CLK);
            POLL_ACK <= 1'b0;
            POLL_PENDING <= ~pend;
        end
    end
endmodule : parent_model

/* verification/cyclic_sleep_controller_tb.sv */
// self-checking bench for the cyclic sleep controller
`timescale 1ns/1ps
module cyclic_sleep_controller_tb;
    import sleep_pkg::*;
    localparam int TK = 4;
    localparam int SP = int'(PERIOD_MIN) * TK;
    localparam int PG = POLL_TICKS * TK;
    // hold must outlast three poll periods, else the third poll meets the expiry
    localparam int HD = 35 * TK;
    typedef struct packed {
        logic        wr;
        logic [2:0]  a;
        logic [15:0] d;
        logic [15:0] e;
    } row_type;
    row_type rows [12] = '{
        '{1'b0, ADDR_MODE, 16'h0000, 16'h0000},
        '{1'b0, ADDR_PERIOD, 16'h0000, 16'h0020},
        '{1'b0, ADDR_MULT, 16'h0000, 16'h0001},
        '{1'b0, ADDR_HOLD, 16'h0000, 16'h01F4},
        '{1'b1, ADDR_PERIOD, 16'h0AF0, 16'h0AF0},
        '{1'b1, ADDR_PERIOD, 16'h0AF1, 16'h0AF0},
        '{1'b1, ADDR_PERIOD, 16'h001F, 16'h0AF0},
        '{1'b1, ADDR_PERIOD, 16'h0020, 16'h0020},
        '{1'b1, ADDR_MULT, 16'h0000, 16'h0001},
        '{1'b1, ADDR_HOLD, 16'h0023, 16'h0023},
        '{1'b1, ADDR_STATUS, 16'h000F, 16'h0000},
        '{1'b1, ADDR_FLOW, 16'h0001, 16'h0001}
    };
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [2:0]  addr = 3'h0;
    logic [15:0] wdata = 16'h0000;
    logic        wr = 1'b0, rd = 1'b0, pin = 1'b0, ser = 1'b0, rad = 1'b0;
    logic        pend = 1'b0, aw = 1'b0, cl = 1'b0;
    logic [3:0]  dly = 4'h1;
    logic [15:0] rdata;
    logic        ack, pnd, poll, awake, cts_n, asleep;
    int          fails = 0;
    int          checks = 0;
    always #10 clk = ~clk;
    always @(posedge clk) begin
        if (awake) aw <= 1'b1;
        if (!cts_n) cl <= 1'b1;
    end
    cyclic_sleep_controller #(.TICK_CYCLES_P(TK)) cyclic_sleep_controller_i (
        .CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .SLEEP_REQUEST_PIN(pin), .SERIAL_DATA(ser), .RADIO_DATA(rad), .POLL_ACK(ack),
        .POLL_PENDING(pnd), .POLL_REQ(poll), .AWAKE(awake), .CTS_N(cts_n), .ASLEEP(asleep));
    parent_model parent_model_i (.CLK(clk), .POLL_REQ(poll), .pend(pend), .dly(dly),
        .POLL_ACK(ack), .POLL_PENDING(pnd));
    task automatic end_sim;
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e) begin
            fails++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic wrt(input logic [2:0] a, input logic [15:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask : wrt
    // outputs read right after an edge show the cycle that edge closed
    task automatic rdc(input logic [2:0] a, input logic [15:0] e);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        chk(rdata, e);
    endtask : rdc
    task automatic hold_for(input int sel, input int lim, output int n);
        n = 0;
        while (!(sel == 0 ? poll : asleep) && n < lim) begin
            @(posedge clk);
            n++;
        end
        if (n >= lim) begin
            fails++;
            $display("unexpected at %0t: wait %h reached %h", $time, sel, lim);
            end_sim();
        end
    endtask : hold_for
    task automatic pulse(input int which);
        if (which == 0) ser <= 1'b1; else rad <= 1'b1;
        @(posedge clk);
        ser <= 1'b0;
        rad <= 1'b0;
    endtask : pulse
    initial begin
        int n;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk(16'({poll, awake, cts_n, asleep}), 16'h0002);
        foreach (rows[i]) begin
            if (rows[i].wr) wrt(rows[i].a, rows[i].d);
            rdc(rows[i].a, rows[i].e);
        end
        wrt(ADDR_MODE, 16'h0004);
        hold_for(1, 8, n);
        repeat (10) @(posedge clk);
        pin <= 1'b1;
        pulse(0);
        pin <= 1'b0;
        repeat (4) @(posedge clk);
        chk(16'({asleep, awake}), 16'h0002);
        hold_for(0, 200, n);
        chk(16'(n + 16 > SP - 5 && n + 16 < SP + 9), 16'h0001);
        repeat (2) @(posedge clk);
        hold_for(1, 30, n);
        chk(16'({aw, cl}), 16'h0003);
        wrt(ADDR_MODE, 16'h0005);
        repeat (10) @(posedge clk);
        pin <= 1'b1;
        repeat (2) @(posedge clk);
        pin <= 1'b0;
        hold_for(0, 12, n);
        pend <= 1'b1;
        repeat (2) @(posedge clk);
        hold_for(0, 300, n);
        repeat (2) @(posedge clk);
        hold_for(0, 60, n);
        pend <= 1'b0;
        @(posedge clk);
        hold_for(0, 60, n);
        chk(16'(n + 1 > PG - 4 && n + 1 < PG + 4), 16'h0001);
        pulse(0);
        hold_for(1, 200, n);
        chk(16'(n > HD - 8 && n < HD + 6), 16'h0001);
        pend <= 1'b1;
        hold_for(0, 200, n);
        repeat (20) @(posedge clk);
        wrt(ADDR_COMMAND, 16'h0001);
        hold_for(1, 4, n);
        pend <= 1'b0;
        dly <= 4'h9;
        wrt(ADDR_MULT, 16'h0002);
        aw <= 1'b0;
        for (int w = 0; w < 2; w++) begin
            hold_for(0, 200, n);
            repeat (2) @(posedge clk);
            hold_for(1, 30, n);
            chk(16'(aw), 16'(w));
            aw <= 1'b0;
        end
        hold_for(0, 200, n);
        pulse(1);
        repeat (2) @(posedge clk);
        chk(16'(awake), 16'h0001);
        wrt(ADDR_OPTIONS, 16'h0006);
        wrt(ADDR_COMMAND, 16'h0001);
        hold_for(1, 4, n);
        hold_for(0, 600, n);
        chk(16'(n > 2 * SP - 5 && n < 2 * SP + 9), 16'h0001);
        repeat (14) @(posedge clk);
        chk(16'(asleep), 16'h0000);
        pulse(0);
        end_sim();
    end
endmodule : cyclic_sleep_controller_tb
